/* inc/pport_pkg.sv */
// package for the parallel port address, pin and slave status block
// assumes a 32-bit avalon-mm slave bus and one core clock
package pport_pkg;
	localparam logic [3:0] ADDR_REG_OFS = 4'h0;
	localparam logic [3:0] PIN_EN_OFS = 4'h4;
	localparam logic [3:0] STATUS_OFS = 4'h8;
	localparam logic [3:0] CTRL_OFS = 4'hC;
	localparam int STAT_IN_ALL = 15;
	localparam int STAT_IN_OVF = 14;
	localparam int STAT_OUT_ALL = 7;
	localparam int STAT_OUT_UNF = 6;
	localparam int CTRL_CSF_LO = 0;
	localparam int CTRL_MUX_LO = 2;
	localparam int CTRL_SLAVE = 4;
	localparam int CTRL_INCM_LO = 5;
	localparam logic [1:0] CSF_ADDR = 2'h0;
	localparam logic [1:0] CSF_ONE_CS = 2'h1;
	localparam logic [1:0] CSF_TWO_CS = 2'h2;
	localparam logic [1:0] INC_UP = 2'h1;
	localparam logic [1:0] INC_DOWN = 2'h2;
	localparam logic [15:0] ADDR_RST = 16'h0000;
	localparam logic [15:0] PIN_EN_RST = 16'h0000;
	localparam logic [3:0] IN_FULL_RST = 4'h0;
	localparam logic [3:0] OUT_EMPTY_RST = 4'hF;
	localparam logic [6:0] CTRL_RST = 7'h00;
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_DONE = 2'b10
	} bus_state_e;
	typedef struct packed {
		logic [15:0] address;
		logic [15:0] pin_enable;
		logic [6:0] ctrl;
		logic [3:0] in_full;
		logic [3:0] out_empty;
		logic input_overflow;
		logic output_underflow;
		logic port_error_interrupt;
		logic [15:0] pin_value;
		logic [15:0] pin_owned;
		logic waitreq;
		logic [31:0] rdata;
		bus_state_e bus_state;
	} pport_state_s;
	typedef struct packed {
		logic [3:0] in_write;
		logic [3:0] out_read;
		logic [3:0] sw_in_read;
		logic [3:0] sw_out_write;
		logic xfer_done;
	} buffer_events_s;
endpackage : pport_pkg

/* core/pport_addr_status.sv */
// address register, pin enables and slave buffer status of a parallel port
// assumes buffer events arrive as one-cycle pulses synchronous to core_clk
// Summary of operation
// (RL1) csf 10/01: bit 15 is chip select two
// (RL2) csf 00: bit 15 drives address pin 15
// (RL3) csf 10: bit 14 is chip select one
// (RL4) csf 00/01: bit 14 drives address pin 14
// (RL5) bits 13..0 always form low address
// (RL6) enable 15:14 gives top pins to port
// (RL7) enables 13..2 make address lines
// (RL8) enables 1:0 give address or latch strobes; the code drives no strobes and holds pins 1:0 at zero when multiplexed
// (RL9) status flags meaningful in slave modes only
// (RL10) all-full set when every input buffer full
// (RL11) overflow on write to full input buffer
// (RL12) per-input full flags, cleared by software read
// (RL13) all-empty set when every output buffer empty
// (RL14) underflow on host read of empty buffer
// (RL15) per-output empty flags, cleared by software write
// (RL16) overflow or underflow raises error interrupt
// (RL17) csf encodes 10, 01, 00; 11 reserved
// (RL18) chip select bits skip auto increment
// (RL19) reset: inputs clear, outputs empty, registers zero
// (RL20) sticky errors cleared by writing zero
//
// Design decisions made here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module pport_addr_status
	import pport_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// avalon-mm slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// buffer events
	input wire buffer_events_s buf_events,
	// pins and interrupt
	output logic [15:0] port_pin_value,
	output logic [15:0] port_pin_owned,
	output logic port_error_interrupt
);
	pport_state_s st_reg;
	pport_state_s st_next;
	logic [1:0] chip_select_function;
	logic [1:0] incm;
	logic slave_mode;
	logic [15:0] wmask;
	logic [15:0] wdat;
	logic [15:0] addr_step;
	logic [15:0] pins;
	logic [3:0] in_full_n;
	logic [3:0] out_empty_n;
	always_comb
	begin
		st_next = st_reg;
		chip_select_function = st_reg.ctrl[CTRL_CSF_LO +: 2];
		incm = st_reg.ctrl[CTRL_INCM_LO +: 2];
		slave_mode = st_reg.ctrl[CTRL_SLAVE];
		wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
		wdat = avs_writedata[15:0];
		addr_step = st_reg.address;
		in_full_n = st_reg.in_full;
		out_empty_n = st_reg.out_empty;
		// auto increment; chip select bits held
		if (buf_events.xfer_done && incm == INC_UP)
			addr_step = st_reg.address + 16'h0001;
		else if (buf_events.xfer_done && incm == INC_DOWN)
			addr_step = st_reg.address - 16'h0001;
		if (chip_select_function != CSF_ADDR)
			addr_step[15] = st_reg.address[15]; // RL18
		if (chip_select_function == CSF_TWO_CS)
			addr_step[14] = st_reg.address[14]; // RL18
		st_next.address = addr_step;
		// buffer flags track only in slave modes
		if (slave_mode) // RL9
		begin
			in_full_n = (st_reg.in_full & ~buf_events.sw_in_read) | buf_events.in_write; // RL12
			out_empty_n = (st_reg.out_empty & ~buf_events.sw_out_write)
				| buf_events.out_read; // RL15
		end
		// bus access, one wait cycle
		st_next.waitreq = 1'b1;
		case (st_reg.bus_state)
			BUS_IDLE:
			begin
				if (avs_write)
				begin
					st_next.bus_state = BUS_DONE;
					st_next.waitreq = 1'b0;
					case (avs_address)
						ADDR_REG_OFS:
							st_next.address = (addr_step & ~wmask) | (wdat & wmask);
						PIN_EN_OFS:
							st_next.pin_enable = (st_reg.pin_enable & ~wmask) | (wdat & wmask);
						CTRL_OFS:
							if (avs_byteenable[0])
								st_next.ctrl = avs_writedata[6:0];
						default:
						begin
						end
					endcase
				end
				else if (avs_read)
				begin
					st_next.bus_state = BUS_DONE;
					st_next.waitreq = 1'b0;
					case (avs_address)
						ADDR_REG_OFS: st_next.rdata = {16'h0000, st_reg.address};
						PIN_EN_OFS: st_next.rdata = {16'h0000, st_reg.pin_enable};
						STATUS_OFS: st_next.rdata = {16'h0000,
							&st_reg.in_full, st_reg.input_overflow, 2'b00, st_reg.in_full, // RL10
							&st_reg.out_empty, st_reg.output_underflow, 2'b00, // RL13
							st_reg.out_empty};
						CTRL_OFS: st_next.rdata = {25'h0, st_reg.ctrl};
						default: st_next.rdata = 32'h00000000;
					endcase
				end
			end
			BUS_DONE:
				st_next.bus_state = BUS_IDLE;
			default:
				st_next.bus_state = BUS_IDLE;
		endcase
		// sticky errors: write zero clears, set wins
		if (st_reg.bus_state == BUS_IDLE && avs_write && avs_address == STATUS_OFS)
		begin
			if (avs_byteenable[1] && !avs_writedata[STAT_IN_OVF])
				st_next.input_overflow = 1'b0; // RL20
			if (avs_byteenable[0] && !avs_writedata[STAT_OUT_UNF])
				st_next.output_underflow = 1'b0; // RL20
		end
		if (slave_mode && |(buf_events.in_write & st_reg.in_full))
			st_next.input_overflow = 1'b1; // RL11
		if (slave_mode && |(buf_events.out_read & st_reg.out_empty))
			st_next.output_underflow = 1'b1; // RL14
		st_next.in_full = in_full_n;
		st_next.out_empty = out_empty_n;
		st_next.port_error_interrupt = st_next.input_overflow | st_next.output_underflow; // RL16
		// pin mapping from next register values
		pins = {2'b00, st_next.address[13:0]}; // RL5
		case (st_next.ctrl[CTRL_CSF_LO +: 2]) // RL17
			CSF_TWO_CS: pins[15:14] = st_next.address[15:14]; // RL1 RL3
			CSF_ONE_CS: pins[15:14] = st_next.address[15:14]; // RL1 RL4
			CSF_ADDR: pins[15:14] = st_next.address[15:14]; // RL2 RL4
			default: pins[15:14] = 2'b00;
		endcase
		// low address pins forced to zero when multiplexed
		if (st_next.ctrl[CTRL_MUX_LO +: 2] != 2'b00)
			pins[1:0] = 2'b00; // RL8
		st_next.pin_value = pins & st_next.pin_enable;
		st_next.pin_owned = st_next.pin_enable; // RL6 RL7 RL8
		if (st_next.ctrl[CTRL_CSF_LO +: 2] == 2'b11)
			st_next.pin_owned[15:14] = 2'b00;
	end
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st_reg <= '0;
			st_reg.address <= ADDR_RST; // RL19
			st_reg.pin_enable <= PIN_EN_RST; // RL19
			st_reg.ctrl <= CTRL_RST;
			st_reg.in_full <= IN_FULL_RST; // RL19
			st_reg.out_empty <= OUT_EMPTY_RST; // RL19
			st_reg.waitreq <= 1'b1;
			st_reg.bus_state <= BUS_IDLE;
		end
		else if (clk_en)
			st_reg <= st_next;
	end
	assign avs_readdata = st_reg.rdata;
	assign avs_waitrequest = st_reg.waitreq;
	assign port_pin_value = st_reg.pin_value;
	assign port_pin_owned = st_reg.pin_owned;
	assign port_error_interrupt = st_reg.port_error_interrupt;
	overflow_sets_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RL11
		clk_en && st_reg.ctrl[CTRL_SLAVE] && |(buf_events.in_write & st_reg.in_full)
		|=> st_reg.input_overflow)
		else $error("overflow not set");
	underflow_sets_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RL14
		clk_en && st_reg.ctrl[CTRL_SLAVE] && |(buf_events.out_read & st_reg.out_empty)
		|=> st_reg.output_underflow)
		else $error("underflow not set");
	error_irq_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RL16
		port_error_interrupt == (st_reg.input_overflow | st_reg.output_underflow))
		else $error("error interrupt mismatch");
	full_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RL12
		clk_en && st_reg.ctrl[CTRL_SLAVE] && buf_events.sw_in_read[0]
		&& !buf_events.in_write[0] |=> !st_reg.in_full[0])
		else $error("full flag not cleared");
	empty_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RL15
		clk_en && st_reg.ctrl[CTRL_SLAVE] && buf_events.sw_out_write[0]
		&& !buf_events.out_read[0] |=> !st_reg.out_empty[0])
		else $error("empty flag not cleared");
	cs_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RL18
		clk_en && !avs_write && st_reg.ctrl[CTRL_CSF_LO +: 2] == CSF_TWO_CS
		|=> $stable(st_reg.address[15:14]))
		else $error("chip select bits changed");
	low_addr_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RL5 RL7
		port_pin_value[13:2] == (st_reg.address[13:2] & st_reg.pin_enable[13:2]))
		else $error("low address pins wrong");
	bus_answer_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && st_reg.bus_state == BUS_IDLE && (avs_read || avs_write)
		|=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer timing wrong");
	sticky_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RL20
		clk_en && st_reg.bus_state == BUS_IDLE && avs_write && avs_address == STATUS_OFS
		&& avs_byteenable[1] && avs_writedata[STAT_IN_OVF] && !st_reg.input_overflow
		&& !(|buf_events.in_write) |=> !st_reg.input_overflow)
		else $error("write one set overflow");
	pin_owned_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RL7
		port_pin_owned[13:0]
		== st_reg.pin_enable[13:0])
		else $error("owned low pins wrong");
	top_owned_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RL6 RL17
		port_pin_owned[15:14] == ((st_reg.ctrl[CTRL_CSF_LO +: 2] == 2'b11)
		? 2'b00 : st_reg.pin_enable[15:14]))
		else $error("owned top pins wrong");
	top_pins_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RL1 RL2 RL3 RL4
		st_reg.ctrl[CTRL_CSF_LO +: 2] != 2'b11
		|-> port_pin_value[15:14] == (st_reg.address[15:14] & st_reg.pin_enable[15:14]))
		else $error("top pins wrong");
	latch_pins_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RL8
		st_reg.ctrl[CTRL_MUX_LO +: 2] != 2'b00
		|-> port_pin_value[1:0] == 2'b00)
		else $error("latch pins wrong");
	addr_pins_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RL8
		st_reg.ctrl[CTRL_MUX_LO +: 2] == 2'b00
		|-> port_pin_value[1:0] == (st_reg.address[1:0] & st_reg.pin_enable[1:0]))
		else $error("low address pins wrong");
	all_full_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RL10
		clk_en && st_reg.bus_state == BUS_IDLE && !avs_write && avs_read
		&& avs_address == STATUS_OFS |=> avs_readdata[STAT_IN_ALL] == (&$past(st_reg.in_full)))
		else $error("all full flag wrong");
	all_empty_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RL13
		clk_en && st_reg.bus_state == BUS_IDLE && !avs_write && avs_read
		&& avs_address == STATUS_OFS |=> avs_readdata[STAT_OUT_ALL] == (&$past(st_reg.out_empty)))
		else $error("all empty flag wrong");
	status_hi_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RL12
		clk_en && st_reg.bus_state == BUS_IDLE && !avs_write && avs_read
		&& avs_address == STATUS_OFS |=> avs_readdata[11:8] == $past(st_reg.in_full))
		else $error("full flags read wrong");
	status_lo_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RL15
		clk_en && st_reg.bus_state == BUS_IDLE && !avs_write && avs_read
		&& avs_address == STATUS_OFS |=> avs_readdata[3:0] == $past(st_reg.out_empty))
		else $error("empty flags read wrong");
	master_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RL9
		clk_en && !st_reg.ctrl[CTRL_SLAVE]
		|=> $stable({st_reg.in_full, st_reg.out_empty}))
		else $error("flags moved in master mode");
	freeze_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		!clk_en
		|=> $stable(st_reg))
		else $error("state moved while frozen");
	overflow_keep_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RL11
		st_reg.input_overflow && !(clk_en && st_reg.bus_state == BUS_IDLE && avs_write
		&& avs_address == STATUS_OFS) |=> st_reg.input_overflow)
		else $error("overflow cleared by hardware");
	underflow_keep_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RL14
		st_reg.output_underflow && !(clk_en && st_reg.bus_state == BUS_IDLE && avs_write
		&& avs_address == STATUS_OFS) |=> st_reg.output_underflow)
		else $error("underflow cleared by hardware");
	full_set_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RL12
		clk_en && st_reg.ctrl[CTRL_SLAVE] && buf_events.in_write[0]
		|=> st_reg.in_full[0])
		else $error("full flag not set");
	empty_set_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RL15
		clk_en && st_reg.ctrl[CTRL_SLAVE] && buf_events.out_read[0]
		|=> st_reg.out_empty[0])
		else $error("empty flag not set");
	pin_write_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RL6 RL7
		clk_en && st_reg.bus_state == BUS_IDLE && avs_write && avs_address == PIN_EN_OFS
		&& avs_byteenable[1:0] == 2'b11 |=> st_reg.pin_enable == $past(avs_writedata[15:0]))
		else $error("pin enable write lost");
	addr_write_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RL5
		clk_en && st_reg.bus_state == BUS_IDLE && avs_write && avs_address == ADDR_REG_OFS
		&& avs_byteenable[1:0] == 2'b11 |=> st_reg.address == $past(avs_writedata[15:0]))
		else $error("address write lost");
	read_upper_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && st_reg.bus_state == BUS_IDLE && !avs_write && avs_read
		|=> avs_readdata[31:16] == 16'h0000)
		else $error("upper read half not zero");
	cs_one_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RL18
		clk_en && !avs_write && st_reg.ctrl[CTRL_CSF_LO +: 2] == CSF_ONE_CS
		|=> $stable(st_reg.address[15]))
		else $error("chip select two bit changed");
	irq_follow_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RL16
		st_reg.input_overflow || st_reg.output_underflow
		|-> port_error_interrupt)
		else $error("error interrupt missing");
	answer_once_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && st_reg.bus_state == BUS_DONE
		|=> avs_waitrequest)
		else $error("answer held too long");
endmodule : pport_addr_status

/* bench/host_model.sv */
// host side model: pulses buffer events the way an external host would
// assumes it is driven from rising edges of core_clk
`timescale 1ns/100ps
module host_model
	import pport_pkg::*;
(
	// clock
	input wire logic core_clk,
	// events
	output buffer_events_s ev
);
	initial ev = '0;
	// one-cycle event, launched and dropped on rising edges
	task automatic pulse(input buffer_events_s e);
		@(posedge core_clk);
		ev <= e;
		@(posedge core_clk);
		ev <= '0;
	endtask : pulse
endmodule : host_model

/* bench/pport_addr_status_bench.sv */
// self-checking bench of the address, pin and status block
// assumes host_model drives buffer events and the bench is the bus master
`timescale 1ns/100ps
module pport_addr_status_bench;
	import pport_pkg::*;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic clk_en = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	buffer_events_s ev;
	logic [15:0] pins;
	logic [15:0] owned;
	logic irq;
	int errors = 0;
	int n_compared = 0;
	int cycles = 0;
	always #20 core_clk = ~core_clk;
	pport_addr_status dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.buf_events(ev), .port_pin_value(pins), .port_pin_owned(owned),
		.port_error_interrupt(irq));
	host_model host_u (.core_clk(core_clk), .ev(ev));
	task automatic conclude();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude
	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			errors++;
			conclude();
		end
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e)
		begin
			errors++;
			$display("BAD %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	// one bus cycle, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge core_clk);
		avs_write <= w;
		avs_read <= !w;
		avs_address <= a;
		avs_writedata <= d;
		do
			@(posedge core_clk);
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic rc(input logic [3:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask : rc
	task automatic t_reset();
		rc(ADDR_REG_OFS, 32'h0);
		rc(PIN_EN_OFS, 32'h0);
		rc(STATUS_OFS, 32'h0000008F);
		rc(CTRL_OFS, 32'h0);
		rc(4'h2, 32'h0);
		chk({31'h0, irq}, 32'h0);
	endtask : t_reset
	task automatic t_pins();
		logic [1:0] chip_select_function;
		wr(ADDR_REG_OFS, 32'h0000C5A3);
		wr(PIN_EN_OFS, 32'h0000A5C3);
		rc(PIN_EN_OFS, 32'h0000A5C3);
		chk({16'h0, owned}, 32'h0000A5C3);
		wr(PIN_EN_OFS, 32'h0000FFFF);
		for (int i = 0; i < 4; i++)
		begin
			chip_select_function = i[1:0];
			wr(CTRL_OFS, {30'h0, chip_select_function});
			rc(ADDR_REG_OFS, 32'h0000C5A3);
			chk({16'h0, owned}, (chip_select_function == 2'h3) ? 32'h00003FFF : 32'h0000FFFF);
			if (chip_select_function != 2'h3)
				chk({16'h0, pins}, 32'h0000C5A3);
		end
		wr(CTRL_OFS, 32'h00000004);
		rc(ADDR_REG_OFS, 32'h0000C5A3);
		chk({16'h0, pins}, 32'h0000C5A0);
	endtask : t_pins
	// control, start address, address after one transfer
	task automatic t_incr();
		logic [31:0] tab [3][3] = '{'{32'h22, 32'hBFFF, 32'h8000},
			'{32'h20, 32'h3FFF, 32'h4000}, '{32'h42, 32'h4000, 32'h7FFF}};
		for (int i = 0; i < 3; i++)
		begin
			wr(CTRL_OFS, tab[i][0]);
			wr(ADDR_REG_OFS, tab[i][1]);
			host_u.pulse('{xfer_done: 1'b1, default: '0});
			rc(ADDR_REG_OFS, tab[i][2]);
		end
	endtask : t_incr
	task automatic t_status();
		wr(CTRL_OFS, 32'h0);
		host_u.pulse('{in_write: 4'h1, default: '0});
		rc(STATUS_OFS, 32'h0000008F);
		wr(CTRL_OFS, 32'h00000010);
		host_u.pulse('{in_write: 4'hF, default: '0});
		rc(STATUS_OFS, 32'h00008F8F);
		host_u.pulse('{in_write: 4'h1, default: '0});
		rc(STATUS_OFS, 32'h0000CF8F);
		chk({31'h0, irq}, 32'h1);
		host_u.pulse('{sw_in_read: 4'h1, default: '0});
		rc(STATUS_OFS, 32'h00004E8F);
		host_u.pulse('{out_read: 4'h4, default: '0});
		rc(STATUS_OFS, 32'h00004ECF);
		host_u.pulse('{sw_out_write: 4'h4, default: '0});
		rc(STATUS_OFS, 32'h00004E4B);
		wr(STATUS_OFS, 32'h0000FFFF);
		rc(STATUS_OFS, 32'h00004E4B);
		chk({31'h0, irq}, 32'h1);
		wr(STATUS_OFS, 32'h0);
		rc(STATUS_OFS, 32'h00000E0B);
		chk({31'h0, irq}, 32'h0);
	endtask : t_status
	// events while the clock enable is low must be lost
	task automatic t_freeze();
		@(posedge core_clk);
		clk_en <= 1'b0;
		host_u.pulse('{in_write: 4'h1, default: '0});
		clk_en <= 1'b1;
		rc(STATUS_OFS, 32'h00000E0B);
		host_u.pulse('{in_write: 4'h1, default: '0});
		rc(STATUS_OFS, 32'h00008F0B);
	endtask : t_freeze
	initial
	begin
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
		t_reset();
		t_pins();
		t_incr();
		t_status();
		t_freeze();
		conclude();
	end
endmodule : pport_addr_status_bench
